// ===== bench/adcoc_bench.sv
// bench joining the converter end and the capture end
`timescale 1ns/10ps
module adcoc_bench;
  import adcoc_pkg::*;
  // long enough to outlast the forced pull at full rate
  localparam int CAL_N = 16;
  logic clk_sys, rst, analog_over, ref_sel, halve_n, tc_n, wr, rd;
  logic irq, use_ext, calibrating;
  logic [7:0] analog_code;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  int mismatches, check_count;
  int cycles = 0;
  adcoc_link_if link ();
  adcoc_device #(.CAL_CYCLES(CAL_N)) adcoc_device_i (.clk_sys(clk_sys),
    .rst(rst), .link(link), .analog_code(analog_code),
    .analog_over(analog_over), .reference_source_select(ref_sel),
    .clock_halve_select_n(halve_n), .twos_complement_select_n(tc_n),
    .use_external_reference(use_ext), .calibrating(calibrating));
  adcoc_host adcoc_host_i (.clk_sys(clk_sys), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  adcoc_chk #(.CAL_CYCLES(CAL_N)) adcoc_chk_i (.clk_sys(clk_sys),
    .rst(rst), .sample_code(link.sample_code), .over_range(link.over_range),
    .forwarded_sample_clock(link.forwarded_sample_clock),
    .reset_n_dev_oe(link.reset_n_dev_oe),
    .reset_n_host_oe(link.reset_n_host_oe),
    .reset_n_line(link.reset_n_line));
  // ---------------------------------------------------------------
  // clock, timeout and reporting
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // register port and waits
  // ---------------------------------------------------------------
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  task automatic wait_code(logic [7:0] v, output int n);
    n = 0;
    while (link.sample_code !== v && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic wait_line_high();
    int n;
    n = 0;
    while (link.reset_n_line !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check("line released", link.reset_n_line, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic run_reference();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      ref_sel <= r[0];
      repeat (5) @(posedge clk_sys);
      check("reference", use_ext, r[0]);
    end
  endtask
  task automatic run_formats();
    logic [7:0] v, expc;
    logic [31:0] d;
    int n, k;
    for (int m = 0; m < 4; m++) begin
      check("rate held in cal", calibrating, 1'b0);
      @(posedge clk_sys);
      halve_n <= m[0];
      tc_n <= m[1];
      // old word refills under the new mode before the timed sample
      repeat (80) @(posedge clk_sys);
      v = 8'hC3 ^ m[7:0];
      k = m[0] ? 1 : 2;
      analog_code <= v;
      analog_over <= m[0];
      expc = m[1] ? v : v ^ MIDSCALE_FLIP;
      wait_code(expc, n);
      check("code", link.sample_code, expc);
      check("over range", link.over_range, m[0]);
      check("output clock", link.forwarded_sample_clock, 1'b1);
      check("latency", n >= LATENCY_CYCLES * k &&
        n <= LATENCY_CYCLES * k + 4, 1'b1);
      rd_reg(ADDR_SAMPLE, d);
      check("captured", d, {23'h0, m[0], expc});
    end
  endtask
  task automatic run_recal();
    logic [31:0] d;
    wr_reg(ADDR_IRQ_STATUS, 32'h0000_0007);
    wr_reg(ADDR_IRQ_MASK, 32'h0000_0000);
    wr_reg(ADDR_CONTROL, 32'h0000_0001);
    rd_reg(ADDR_CONTROL, d);
    check("driving", d[0], 1'b1);
    repeat (14) @(posedge clk_sys);
    check("recalibrating", calibrating, 1'b1);
    check("irq masked", irq, 1'b0);
    rd_reg(ADDR_STATUS, d);
    check("status line low", d[0], 1'b1);
    wait_line_high();
    rd_reg(ADDR_STATUS, d);
    check("status after cal", d, 32'h0000_0002);
    rd_reg(ADDR_IRQ_STATUS, d);
    check("cal done event", d[2], 1'b1);
    wr_reg(ADDR_IRQ_MASK, 32'h0000_0004);
    @(negedge clk_sys);
    check("irq raised", irq, 1'b1);
    wr_reg(ADDR_IRQ_STATUS, 32'h0000_0004);
    @(negedge clk_sys);
    check("irq cleared", irq, 1'b0);
    rd_reg(4'hF, d);
    check("unmapped", d, 32'h0000_0000);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    analog_code = 8'h00;
    analog_over = 1'b0;
    ref_sel = 1'b0;
    halve_n = 1'b1;
    tc_n = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check("power-up cal", calibrating, 1'b1);
    wait_line_high();
    run_reference();
    run_formats();
    run_recal();
    complete_run();
  end
endmodule // adcoc_bench

// ===== bench/adcoc_chk.sv
// link assertions for the converter control ends
`timescale 1ns/10ps
module adcoc_chk #(
  parameter int CAL_CYCLES = adcoc_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adcoc_pkg::SAMPLE_WIDTH-1:0] sample_code,
  input wire logic over_range,
  input wire logic forwarded_sample_clock,
  input wire logic reset_n_dev_oe,
  input wire logic reset_n_host_oe,
  input wire logic reset_n_line
);
  import adcoc_pkg::*;
  // ---------------------------------------------------------------
  // pull length counters
  // ---------------------------------------------------------------
  logic [7:0] host_cnt_reg;
  logic [9:0] cal_cnt_reg;
  always_ff @(posedge clk_sys) begin
    host_cnt_reg <= (rst | ~reset_n_host_oe) ? 8'h00 : host_cnt_reg + 8'h01;
    cal_cnt_reg <= (rst | ~reset_n_dev_oe) ? 10'h000 : cal_cnt_reg + 10'h001;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_powerup_cal: assert property (
    $fell(rst) |-> ##[0:2] reset_n_dev_oe) else $error("no power-up cal");
  a_cal_length: assert property (
    $fell(reset_n_dev_oe) |-> cal_cnt_reg >= CAL_CYCLES &&
    cal_cnt_reg <= 2 * CAL_CYCLES + 3) else $error("cal length wrong");
  a_quiet_in_cal: assert property (
    reset_n_dev_oe [*3] |-> $stable(sample_code) && $stable(over_range))
    else $error("word moved during cal");
  a_clock_after_word: assert property (
    $changed(sample_code) |-> forwarded_sample_clock)
    else $error("no output clock after word");
  a_flag_with_clock: assert property (
    $changed(over_range) |-> forwarded_sample_clock)
    else $error("flag not paired with clock");
  a_line_held: assert property (
    reset_n_dev_oe |-> !reset_n_line)
    else $error("line not low during cal");
  a_force_length: assert property (
    $fell(reset_n_host_oe) |-> host_cnt_reg == 8'h16)
    else $error("forced pull length wrong");
  a_force_recal: assert property (
    $fell(reset_n_host_oe) |-> ##[0:6] reset_n_dev_oe)
    else $error("forced pull gave no recal");
  a_idle_after_reset: assert property (
    $fell(rst) |-> sample_code == SAMPLE_RESET && !over_range &&
    !forwarded_sample_clock) else $error("link not idle after reset");
  c_forced: cover property ($fell(reset_n_host_oe));
  c_over: cover property ($rose(over_range));
  c_cal_end: cover property ($fell(reset_n_dev_oe));
  c_halved: cover property ($fell(forwarded_sample_clock));
endmodule // adcoc_chk

// ===== src/adcoc_device.sv
// converter output, clock-halve and calibration control end
//
// Overview of operation
// - code appears 28 sample cycles after start
// - calibrate at power-up, hold reset low
// - keep sample clock fixed while calibrating
// - recalibrate if rate moves over 10% (no rate monitor here; only a forced low restarts it)
// - reset low ten cycles forces recalibration
// - external reset driver open-drain, no pull-up
// - reference select 0 internal, 1 external
// - clock halve select active low halves clock
// - halve low ratio 2, else 1, rising edges
// - twos complement select low gives signed codes
// - select high gives straight binary codes
// - eight-bit word, bit 0 least significant
// - output clock forwarded with the data
`timescale 1ns/10ps
module adcoc_device
  import adcoc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  adcoc_link_if.device link,
  input wire logic [adcoc_pkg::SAMPLE_WIDTH-1:0] analog_code,
  input wire logic analog_over,
  input wire logic reference_source_select,
  input wire logic clock_halve_select_n,
  input wire logic twos_complement_select_n,
  output logic use_external_reference,
  output logic calibrating
);
  import adcoc_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers: three flops, change taken when 2 and 3 agree
  // ---------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] stable_reg;
  wire [3:0] pins_raw = {link.reset_n_line, reference_source_select,
                         clock_halve_select_n, twos_complement_select_n};
  wire [3:0] stable_next = (sync2_reg & sync3_reg) |
                           (stable_reg & (sync2_reg | sync3_reg));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
      stable_reg <= 4'hF;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  wire line_n = stable_reg[3];
  wire ref_ext = stable_reg[2];
  wire halve_n = stable_reg[1];
  wire twos_n = stable_reg[0];

  assign use_external_reference = ref_ext;

  // ---------------------------------------------------------------
  // clock halving: effective sample strobe
  // ---------------------------------------------------------------
  logic phase_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  // floating or high pin leaves the clock undivided
  wire sample_en = halve_n ? 1'b1 : phase_reg;

  // ---------------------------------------------------------------
  // calibration and forced reset
  // ---------------------------------------------------------------
  adcoc_state_type state_reg;
  adcoc_state_type state_next;
  logic [CAL_COUNT_WIDTH-1:0] cal_count_reg;
  logic [3:0] low_count_reg;
  localparam logic [CAL_COUNT_WIDTH-1:0] CAL_LAST =
    CAL_COUNT_WIDTH'(CAL_CYCLES - 1);
  localparam logic [3:0] FORCE_LAST = 4'(FORCE_RESET_CYCLES - 1);

  // an external low only counts once we have released the line
  wire ext_low = ~line_n & (state_reg == ADCOC_RUN);
  wire force_hit = ext_low & sample_en & (low_count_reg == FORCE_LAST);
  wire cal_done = (state_reg == ADCOC_CAL) & sample_en &
                  (cal_count_reg == CAL_LAST);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ADCOC_IDLE: state_next = ADCOC_CAL;
      ADCOC_CAL: if (cal_done) state_next = ADCOC_RUN;
      ADCOC_RUN: if (force_hit) state_next = ADCOC_CAL;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ADCOC_IDLE;
      cal_count_reg <= '0;
      low_count_reg <= FORCE_COUNT_RESET;
    end else begin
      state_reg <= state_next;
      if (state_reg != ADCOC_CAL) begin
        cal_count_reg <= '0;
      end else if (sample_en) begin
        cal_count_reg <= cal_count_reg + 1'b1;
      end
      // counted in effective sample periods
      if (!ext_low || force_hit) begin
        low_count_reg <= FORCE_COUNT_RESET;
      end else if (sample_en) begin
        low_count_reg <= low_count_reg + 1'b1;
      end
    end
  end

  assign calibrating = (state_reg != ADCOC_RUN);
  // open drain: only ever drive low
  assign link.reset_n_dev_o = 1'b0;
  assign link.reset_n_dev_oe = calibrating;

  // ---------------------------------------------------------------
  // conversion pipeline: 28 effective sample cycles
  // ---------------------------------------------------------------
  logic [SAMPLE_WIDTH:0] pipe_reg [LATENCY_CYCLES];
  genvar g;
  generate
    for (g = 0; g < LATENCY_CYCLES; g++) begin : g_pipe
      wire [SAMPLE_WIDTH:0] stage_in;
      // head stage chosen at elaboration, so no stage reads index -1
      if (g == 0) begin : g_head
        assign stage_in = {analog_over, analog_code};
      end else begin : g_tail
        assign stage_in = pipe_reg[g-1];
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pipe_reg[g] <= '0;
        end else if (sample_en) begin
          pipe_reg[g] <= stage_in;
        end
      end
    end
  endgenerate

  wire [SAMPLE_WIDTH:0] pipe_out = pipe_reg[LATENCY_CYCLES-1];
  // signed form flips the msb of the offset-binary code
  wire [SAMPLE_WIDTH-1:0] code_fmt = twos_n ?
    pipe_out[SAMPLE_WIDTH-1:0] :
    pipe_out[SAMPLE_WIDTH-1:0] ^ MIDSCALE_FLIP;

  // ---------------------------------------------------------------
  // output word, flag and forwarded clock
  // ---------------------------------------------------------------
  logic [SAMPLE_WIDTH-1:0] code_reg;
  logic over_reg;
  logic fclk_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_reg <= SAMPLE_RESET;
      over_reg <= 1'b0;
      fclk_reg <= 1'b0;
    end else begin
      // clock is high in the cycle the new word stands; at full rate
      // it stays high outside calibration, so the receiver takes it as a level strobe
      fclk_reg <= sample_en & ~calibrating;
      if (sample_en && !calibrating) begin
        code_reg <= code_fmt;
        over_reg <= pipe_out[SAMPLE_WIDTH];
      end
    end
  end

  assign link.sample_code = code_reg;
  assign link.over_range = over_reg;
  assign link.forwarded_sample_clock = fclk_reg;
endmodule // adcoc_device

// ===== src/adcoc_host.sv
// capture end: takes samples, drives forced recalibration
`timescale 1ns/10ps
module adcoc_host
  import adcoc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  adcoc_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);
  import adcoc_pkg::*;

  // ---------------------------------------------------------------
  // capture while forwarded clock is high (same domain, no sync)
  // ---------------------------------------------------------------
  logic [SAMPLE_WIDTH-1:0] cap_code_reg;
  logic cap_over_reg;
  // a level, not an edge: at full rate the clock only falls during calibration
  wire cap_take = link.forwarded_sample_clock;

  // ---------------------------------------------------------------
  // open-drain recalibration drive, at least ten sample periods
  // ---------------------------------------------------------------
  logic [4:0] drive_count_reg;
  logic line_d_reg;
  localparam logic [4:0] DRIVE_CYCLES = 5'(2 * FORCE_RESET_CYCLES + 2);
  wire ctrl_wr = wr & (addr == ADDR_CONTROL);
  wire recal_go = ctrl_wr & wdata[CTRL_RECAL_BIT];
  wire driving = (drive_count_reg != 5'h00);
  // ten halved periods are twenty clocks, plus margin
  assign link.reset_n_host_o = 1'b0;
  assign link.reset_n_host_oe = driving;
  wire cal_done_ev = link.reset_n_line & ~line_d_reg;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  wire [2:0] irq_events = {cal_done_ev, cap_take & link.over_range,
                           cap_take};
  wire irq_clr_wr = wr & (addr == ADDR_IRQ_STATUS);
  wire [2:0] irq_clr = irq_clr_wr ? wdata[2:0] : 3'h0;
  // set wins over a same-cycle clear
  wire [2:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_events;
  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cap_code_reg <= SAMPLE_RESET;
      cap_over_reg <= 1'b0;
      drive_count_reg <= 5'h00;
      line_d_reg <= 1'b0;
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      line_d_reg <= link.reset_n_line;
      irq_status_reg <= irq_status_next;
      if (cap_take) begin
        cap_code_reg <= link.sample_code;
        cap_over_reg <= link.over_range;
      end
      if (recal_go) begin
        drive_count_reg <= DRIVE_CYCLES;
      end else if (driving) begin
        drive_count_reg <= drive_count_reg - 1'b1;
      end
      if (wr && addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wdata[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register read, data one cycle after the strobe
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (addr == ADDR_CONTROL) ? {31'h0, driving} :
    (addr == ADDR_STATUS) ? {30'h0, cap_over_reg, ~link.reset_n_line} :
    (addr == ADDR_IRQ_STATUS) ? {29'h0, irq_status_reg} :
    (addr == ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
    (addr == ADDR_SAMPLE) ? {23'h0, cap_over_reg, cap_code_reg} :
    32'h0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_mux : 32'h0;
    end
  end
endmodule // adcoc_host

// ===== src/adcoc_link_if.sv
// link between the converter control end and the capture end
`timescale 1ns/10ps
interface adcoc_link_if;
  import adcoc_pkg::*;
  logic [SAMPLE_WIDTH-1:0] sample_code;
  logic over_range;
  logic forwarded_sample_clock;
  logic reset_n_dev_o;
  logic reset_n_dev_oe;
  logic reset_n_host_o;
  logic reset_n_host_oe;
  // open-drain wire, no pull-up: a floating line reads high
  wire reset_n_line = ~((reset_n_dev_oe & ~reset_n_dev_o) |
                        (reset_n_host_oe & ~reset_n_host_o));
  modport device (
    output sample_code, over_range, forwarded_sample_clock,
    output reset_n_dev_o, reset_n_dev_oe,
    input reset_n_line
  );
  modport host (
    input sample_code, over_range, forwarded_sample_clock,
    output reset_n_host_o, reset_n_host_oe,
    input reset_n_line
  );
endinterface

// ===== src/adcoc_pkg.sv
// shared constants and types for the converter control ends
package adcoc_pkg;
  // ---------------------------------------------------------------
  // sample word and pipeline
  // ---------------------------------------------------------------
  localparam int SAMPLE_WIDTH = 8;
  localparam int PIPE_CYCLES = 24;
  localparam int CORRECTION_CYCLES = 4;
  localparam int LATENCY_CYCLES = PIPE_CYCLES + CORRECTION_CYCLES;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
  localparam logic [7:0] MIDSCALE_FLIP = 8'h80;
  // ---------------------------------------------------------------
  // reset line and calibration
  // ---------------------------------------------------------------
  localparam int FORCE_RESET_CYCLES = 10;
  localparam int CAL_CYCLES_DEFAULT = 64;
  localparam int CAL_COUNT_WIDTH = 16;
  localparam logic [3:0] FORCE_COUNT_RESET = 4'h0;
  // ---------------------------------------------------------------
  // host register map (word addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_SAMPLE = 4'h4;
  localparam int CTRL_RECAL_BIT = 0;
  localparam int IRQ_SAMPLE_BIT = 0;
  localparam int IRQ_OVER_BIT = 1;
  localparam int IRQ_CAL_DONE_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  typedef enum {ADCOC_IDLE, ADCOC_CAL, ADCOC_RUN} adcoc_state_type;
endpackage
